// file: dbmr_pkg.sv
// Purpose: shared constants, slot type and latency arithmetic for the burst/readout core
// Assumes: one 100 MHz clock, one data beat per clock on the user side
// Notes: mode register field positions follow the column address bits of the set command
package dbmr_pkg;
    // ----------------------------------------------------------------
    // command codes
    // ----------------------------------------------------------------
    localparam logic [2:0] DBMR_CMD_NOP = 3'h0;
    localparam logic [2:0] DBMR_CMD_READ = 3'h1;
    localparam logic [2:0] DBMR_CMD_WRITE = 3'h2;
    localparam logic [2:0] DBMR_CMD_MRS = 3'h3;
    localparam logic [2:0] DBMR_CMD_LONG_CAL = 3'h4;
    // ----------------------------------------------------------------
    // mode register selects and field positions
    // ----------------------------------------------------------------
    localparam logic [2:0] DBMR_MODE_SEL0 = 3'h0;
    localparam logic [2:0] DBMR_MODE_SEL1 = 3'h1;
    localparam logic [2:0] DBMR_MODE_SEL2 = 3'h2;
    localparam logic [2:0] DBMR_MODE_SEL3 = 3'h3;
    localparam int unsigned DBMR_BF_LSB = 0;
    localparam int unsigned DBMR_LAT_LSB = 3;
    localparam int unsigned DBMR_PAT_EN_BIT = 2;
    localparam int unsigned DBMR_DLL_BIT = 12;
    localparam int unsigned DBMR_A2_BIT = 2;
    localparam int unsigned DBMR_A12_BIT = 12;
    // ----------------------------------------------------------------
    // encodings and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] DBMR_BF_FULL = 2'h0;
    localparam logic [1:0] DBMR_BF_FLY = 2'h1;
    localparam logic [1:0] DBMR_BF_CHOP = 2'h2;
    localparam logic [1:0] DBMR_ADD_ZERO = 2'h0;
    localparam logic [1:0] DBMR_ADD_CAS1 = 2'h1;
    localparam logic [1:0] DBMR_ADD_CAS2 = 2'h2;
    localparam logic [3:0] DBMR_CAS_RST = 4'h5;
    localparam logic [3:0] DBMR_CWL_RST = 4'h5;
    localparam logic [2:0] DBMR_CHOP_LAST = 3'h3;
    localparam logic [2:0] DBMR_FULL_LAST = 3'h7;
    localparam logic [2:0] DBMR_NIB_UPPER = 3'h4;
    localparam logic [2:0] DBMR_NIB_LOWER = 3'h0;
    localparam logic [4:0] DBMR_ONE = 5'h01;

    typedef struct packed {
        logic valid;
        logic chop;
        logic pat;
        logic upper;
    } dbmr_slot_t;

    // additive latency from its mode and the cas latency
    function automatic logic [4:0] dbmr_add_lat(input logic [3:0] cas, input logic [1:0] mode);
        logic [4:0] extra;
        extra = 5'h00;
        if (mode == DBMR_ADD_CAS1)
            extra = {1'b0, cas} - 5'h01;
        else if (mode == DBMR_ADD_CAS2)
            extra = {1'b0, cas} - 5'h02;
        return extra;
    endfunction : dbmr_add_lat
endpackage : dbmr_pkg

// file: dbmr_burst_if.sv
// Purpose: carries one column command's burst selection inputs and the chop answer
// Assumes: driven by the core, answered combinationally by the selector
// Notes: none
interface dbmr_burst_if;
    logic col_cmd;
    logic [1:0] burst_field;
    logic addr12;
    logic chop;
    modport sel (input col_cmd, input burst_field, input addr12, output chop);
    modport user (output col_cmd, output burst_field, output addr12, input chop);
endinterface : dbmr_burst_if

// file: dbmr_burst_sel.sv
// Purpose: decides chopped or full burst for each column command
// Assumes: burst field reserved code 11 is treated as full burst
// Notes: purely combinational; clock only feeds the checks
module dbmr_burst_sel
    import dbmr_pkg::*;
(
    // clock
    input wire logic sys_clk,
    input wire logic rst_n,
    // selection
    dbmr_burst_if.sel bif
);
    // ----------------------------------------------------------------
    // selection
    // ----------------------------------------------------------------
    always_comb
    begin
        bif.chop = (bif.burst_field == DBMR_BF_CHOP) ||
            ((bif.burst_field == DBMR_BF_FLY) && !bif.addr12); // RULE5 RULE6
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_full_burst_sel: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE4
        bif.col_cmd && ((bif.burst_field == DBMR_BF_FULL) ||
        ((bif.burst_field == DBMR_BF_FLY) && bif.addr12)) |-> !bif.chop)
        else $error("full burst selection gave chop");
    a_chop_burst_sel: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE5
        bif.col_cmd && ((bif.burst_field == DBMR_BF_CHOP) ||
        ((bif.burst_field == DBMR_BF_FLY) && !bif.addr12)) |-> bif.chop)
        else $error("chop selection gave full burst");
endmodule : dbmr_burst_sel

// file: dbmr_device.sv
// Purpose: device-side burst length choice, read latency, pattern readout, termination window
// Assumes: one beat per clock on the read data port; array data arrives on array_data
// Notes: all design state is one struct registered in one process; the checks keep read_hist in a process of their own
// Behaviour
// RULE1: controller sends only no-op or deselect between mode set and long calibration.
// RULE2: controller drives column address bits one and zero low for pattern reads.
// RULE3: chopped pattern read returns bits 0-3 if A2 low, bits 4-7 if high.
// RULE4: full eight-beat burst when burst field is 00, or 01 with A12 high.
// RULE5: four-beat chopped burst when burst field is 10, or 01 with A12 low.
// RULE6: on-the-fly mode chooses burst length per command from A12 at that command.
// RULE7: read latency is cas plus additive latency; additive may be cas minus two.
// RULE8: controller holds termination high four clocks after a chopped write; the model has no termination output, only idles four clocks per write.
// RULE9: frozen-loop power-down entry/exit makes termination asynchronous for write latency minus one.
// RULE10: controller spaces column commands by the column-to-column delay.
module dbmr_device
    import dbmr_pkg::*;
#(
    parameter int unsigned PIPE_DEPTH = 32,
    parameter int unsigned DATA_W = 16,
    parameter logic [7:0] READOUT_PATTERN = 8'h55
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // command
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic [2:0] cmd_bank,
    input wire logic [15:0] cmd_addr,
    // power state
    input wire logic cke,
    // array read data
    input wire logic [DATA_W-1:0] array_data,
    // read beats
    output logic rd_valid,
    output logic rd_first,
    output logic rd_last,
    output logic [2:0] rd_beat,
    output logic [DATA_W-1:0] rd_data,
    // status
    output logic burst_chop,
    output logic odt_async
);
    if (PIPE_DEPTH < 30 || DATA_W < 1)
    begin : g_bad_params
        $error("PIPE_DEPTH must cover the longest read latency");
    end

    typedef struct packed {
        logic [1:0] burst_field;
        logic [3:0] cas_lat;
        logic [1:0] add_mode;
        logic [3:0] cwl;
        logic pat_en;
        logic dll_frozen;
        dbmr_slot_t [PIPE_DEPTH-1:0] pipe;
        dbmr_slot_t cur;
        logic [2:0] beats_left;
        logic rd_valid;
        logic rd_first;
        logic rd_last;
        logic [2:0] rd_beat;
        logic [DATA_W-1:0] rd_data;
        logic cmd_chop;
        logic cke_q;
        logic pd;
        logic [4:0] win_cnt;
        logic odt_async;
    } dbmr_state_t;

    dbmr_state_t st;
    dbmr_state_t next_st;
    dbmr_burst_if bif ();
    logic read_taken;
    logic col_taken;
    logic [4:0] read_lat;
    logic [4:0] write_lat;

    // ----------------------------------------------------------------
    // burst length selection
    // ----------------------------------------------------------------
    assign read_taken = cmd_valid && (cmd_code == DBMR_CMD_READ);
    assign col_taken = read_taken || (cmd_valid && (cmd_code == DBMR_CMD_WRITE));
    assign bif.col_cmd = col_taken;
    assign bif.burst_field = st.burst_field;
    assign bif.addr12 = cmd_addr[DBMR_A12_BIT]; // RULE6

    dbmr_burst_sel u_sel (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .bif(bif)
    );

    assign read_lat = {1'b0, st.cas_lat} + dbmr_add_lat(st.cas_lat, st.add_mode); // RULE7
    assign write_lat = {1'b0, st.cwl} + dbmr_add_lat(st.cas_lat, st.add_mode);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        dbmr_slot_t slot;
        logic active;
        logic [2:0] beat_n;
        logic [2:0] left_n;
        logic [2:0] bit_idx;
        next_st = st;
        slot = st.cur;
        active = 1'b0;
        beat_n = st.rd_beat + 3'h1;
        left_n = st.beats_left - 3'h1;
        bit_idx = 3'h0;
        next_st.rd_first = 1'b0;
        next_st.rd_last = 1'b0;
        if (cmd_valid && cmd_code == DBMR_CMD_MRS)
        begin
            unique case (cmd_bank)
                DBMR_MODE_SEL0:
                begin
                    next_st.burst_field = cmd_addr[DBMR_BF_LSB +: 2];
                    next_st.cas_lat = cmd_addr[DBMR_LAT_LSB +: 4];
                    next_st.dll_frozen = !cmd_addr[DBMR_DLL_BIT];
                end
                DBMR_MODE_SEL1: next_st.add_mode = cmd_addr[DBMR_LAT_LSB +: 2];
                DBMR_MODE_SEL2: next_st.cwl = cmd_addr[DBMR_LAT_LSB +: 4];
                DBMR_MODE_SEL3: next_st.pat_en = cmd_addr[DBMR_PAT_EN_BIT];
                default: next_st.pat_en = st.pat_en;
            endcase
        end
        if (col_taken)
            next_st.cmd_chop = bif.chop; // RULE6
        // read pipeline: a slot enters at read_lat-1 and walks down one place a clock
        for (int i = 0; i < PIPE_DEPTH - 1; i++)
            next_st.pipe[i] = st.pipe[i + 1];
        next_st.pipe[PIPE_DEPTH-1] = '0;
        if (read_taken)
        begin
            // column bits one and zero are ignored for pattern reads
            next_st.pipe[read_lat - DBMR_ONE] = '{1'b1, bif.chop, st.pat_en,
                cmd_addr[DBMR_A2_BIT]}; // RULE7 RULE2
        end
        if (st.pipe[0].valid)
        begin
            active = 1'b1;
            slot = st.pipe[0];
            beat_n = 3'h0;
            left_n = slot.chop ? DBMR_CHOP_LAST : DBMR_FULL_LAST; // RULE4 RULE5
        end
        else if (st.rd_valid && st.beats_left != 3'h0)
        begin
            active = 1'b1;
        end
        bit_idx = (slot.upper ? DBMR_NIB_UPPER : DBMR_NIB_LOWER) + beat_n; // RULE3
        next_st.rd_valid = active;
        if (active)
        begin
            next_st.cur = slot;
            next_st.rd_beat = beat_n;
            next_st.beats_left = left_n;
            next_st.rd_first = st.pipe[0].valid;
            next_st.rd_last = (left_n == 3'h0);
            next_st.rd_data = slot.pat ? {DATA_W{READOUT_PATTERN[bit_idx]}} : array_data; // RULE3
        end
        // power-down transitions with a frozen loop
        next_st.cke_q = cke;
        next_st.pd = !cke;
        if (cke != st.cke_q && st.dll_frozen)
            next_st.win_cnt = write_lat - DBMR_ONE; // RULE9
        else if (st.win_cnt != 5'h00)
            next_st.win_cnt = st.win_cnt - DBMR_ONE;
        next_st.odt_async = st.dll_frozen && (next_st.pd || next_st.win_cnt != 5'h00); // RULE9
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.cas_lat <= DBMR_CAS_RST;
            st.cwl <= DBMR_CWL_RST;
            st.cke_q <= 1'b1;
        end
        else
            st <= next_st;
    end

    assign rd_valid = st.rd_valid;
    assign rd_first = st.rd_first;
    assign rd_last = st.rd_last;
    assign rd_beat = st.rd_beat;
    assign rd_data = st.rd_data;
    assign burst_chop = st.cmd_chop;
    assign odt_async = st.odt_async;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [31:0] read_hist;
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            read_hist <= '0;
        else
            read_hist <= {read_hist[30:0], read_taken};
    end

    a_read_latency: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE7
        st.rd_first == read_hist[read_lat])
        else $error("first read beat not at cas plus additive latency");
    a_chop_length: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE5
        st.rd_first && st.cur.chop |-> ##3 st.rd_last)
        else $error("chopped burst did not end after four beats");
    a_full_length: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE4
        st.rd_first && !st.cur.chop |-> (st.rd_valid && !st.rd_last) [*7] ##1 st.rd_last)
        else $error("full burst did not run eight beats");
    a_pattern_nibble: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE3
        st.rd_valid && st.cur.pat && st.cur.chop |-> st.rd_data ==
        {DATA_W{READOUT_PATTERN[{st.cur.upper, st.rd_beat[1:0]}]}})
        else $error("pattern readout returned the wrong nibble");
    a_fly_per_cmd: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE6
        col_taken && st.burst_field == DBMR_BF_FLY |=>
        burst_chop == !$past(cmd_addr[DBMR_A12_BIT]))
        else $error("on-the-fly chop did not follow the command's A12");
    a_async_window: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE9
        st.dll_frozen && cke != st.cke_q |=> st.win_cnt == write_lat - DBMR_ONE && odt_async)
        else $error("asynchronous termination window not started");

    c_chop_pattern: cover property (@(posedge sys_clk) disable iff (!rst_n)
        st.rd_first && st.cur.pat && st.cur.chop && st.cur.upper);
    c_full_read: cover property (@(posedge sys_clk) disable iff (!rst_n)
        st.rd_first && !st.cur.chop);
    c_async_exit: cover property (@(posedge sys_clk) disable iff (!rst_n)
        st.dll_frozen && $rose(cke));
endmodule : dbmr_device

// file: dbmr_ctl_model.sv
// Purpose: behavioural memory controller that issues commands to the device core
// Assumes: commands change on the falling edge, one command cycle each
// Notes: released address and bank lines flip so stale values never pass for live ones
module dbmr_ctl_model
    import dbmr_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // command
    output logic cmd_valid,
    output logic [2:0] cmd_code,
    output logic [2:0] cmd_bank,
    output logic [15:0] cmd_addr,
    // power state
    output logic cke
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int COL_GAP = 8;
    int since_col = COL_GAP;

    initial
    begin
        cmd_valid = 1'b0;
        cmd_code = DBMR_CMD_NOP;
        cmd_bank = 3'h0;
        cmd_addr = 16'h0000;
        cke = 1'b1;
    end

    always @(posedge sys_clk)
        since_col = since_col + 1;

    task automatic send(input logic [2:0] code, input logic [2:0] bank, input logic [15:0] addr);
        logic col;
        col = (code == DBMR_CMD_READ) || (code == DBMR_CMD_WRITE);
        if (code == DBMR_CMD_READ)
            addr[1:0] = 2'h0;
        @(negedge sys_clk);
        while (col && since_col < COL_GAP)
            @(negedge sys_clk);
        if (col)
            since_col = 0;
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_bank = bank;
        cmd_addr = addr;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        cmd_code = DBMR_CMD_NOP;
        cmd_bank = ~cmd_bank;
        cmd_addr = ~cmd_addr;
        // wait four clocks after every write, chopped or not, to cover the termination hold after a chopped write
        if (code == DBMR_CMD_WRITE)
            repeat (4) @(negedge sys_clk);
    endtask : send

    task automatic mode_calib(input logic [2:0] bank, input logic [15:0] addr);
        send(DBMR_CMD_MRS, bank, addr);
        repeat (2) @(negedge sys_clk);
        send(DBMR_CMD_LONG_CAL, 3'h0, 16'h0000);
    endtask : mode_calib

    task automatic set_cke(input logic v);
        @(negedge sys_clk);
        cke = v;
    endtask : set_cke
endmodule : dbmr_ctl_model

// file: dbmr_tb.sv
// Purpose: self-checking bench for the burst and readout device core
// Assumes: controller model drives commands, bench drives array data
// Notes: pattern value makes every nibble distinct
module tb
    import dbmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] PAT = 8'ha6;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid, cke, rd_valid, rd_first, rd_last, burst_chop, odt_async, chop_seen;
    logic [2:0] cmd_code, cmd_bank, rd_beat;
    logic [15:0] cmd_addr, rd_data;
    logic [15:0] array_data = 16'h0000;
    logic [15:0] beats [8];
    int mismatches = 0;
    int compares = 0;
    int lat, nbeat, lastpos;

    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end

    always @(negedge sys_clk)
        array_data <= array_data + 16'h0001;

    dbmr_ctl_model ctl (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .cke(cke));

    dbmr_device #(.READOUT_PATTERN(PAT)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank),
        .cmd_addr(cmd_addr), .cke(cke), .array_data(array_data), .rd_valid(rd_valid),
        .rd_first(rd_first), .rd_last(rd_last), .rd_beat(rd_beat), .rd_data(rd_data),
        .burst_chop(burst_chop), .odt_async(odt_async));

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize

    // one read: latency in edges after the command edge, then the beats
    task automatic do_read(input logic [15:0] addr);
        lat = 0;
        nbeat = 0;
        lastpos = -1;
        ctl.send(DBMR_CMD_READ, 3'h0, addr);
        chop_seen = burst_chop;
        while (rd_first !== 1'b1 && lat < 40)
        begin
            @(negedge sys_clk);
            lat++;
        end
        while (rd_valid === 1'b1 && nbeat < 8)
        begin
            check("rd_beat", 16'(nbeat), {13'h0000, rd_beat});
            beats[nbeat] = rd_data;
            if (rd_last === 1'b1)
                lastpos = nbeat;
            @(negedge sys_clk);
            nbeat++;
        end
        repeat (2) @(negedge sys_clk);
    endtask : do_read

    task automatic t_burst;
        logic [1:0] bf [6] = '{2'h0, 2'h2, 2'h2, 2'h1, 2'h1, 2'h3};
        logic a12 [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        logic chp [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 6; i++)
        begin
            ctl.send(DBMR_CMD_MRS, DBMR_MODE_SEL0, 16'h1028 | {14'h0000, bf[i]});
            do_read({3'h0, a12[i], 12'h000});
            check("burst_chop", {15'h0000, chp[i]}, {15'h0000, chop_seen});
            check("beat count", chp[i] ? 16'h0004 : 16'h0008, 16'(nbeat));
            check("last beat", chp[i] ? 16'h0003 : 16'h0007, 16'(lastpos));
            check("read latency", 16'h0005, 16'(lat));
        end
        ctl.send(DBMR_CMD_MRS, DBMR_MODE_SEL0, 16'h1029);
        ctl.send(DBMR_CMD_WRITE, 3'h0, 16'h0000);
        check("write chop", 16'h0001, {15'h0000, burst_chop});
        do_read(16'h1000);
        check("read after write", 16'h0008, 16'(nbeat));
        $display("test burst done");
    endtask : t_burst

    task automatic t_latency;
        logic [1:0] add_modes [3] = '{DBMR_ADD_ZERO, DBMR_ADD_CAS2, DBMR_ADD_CAS1};
        int exp_lat [3] = '{5, 8, 9};
        for (int i = 0; i < 3; i++)
        begin
            ctl.send(DBMR_CMD_MRS, DBMR_MODE_SEL1, {11'h000, add_modes[i], 3'h0});
            do_read(16'h1000);
            check("read latency", 16'(exp_lat[i]), 16'(lat));
        end
        ctl.send(DBMR_CMD_MRS, DBMR_MODE_SEL1, 16'h0000);
        $display("test latency done");
    endtask : t_latency

    task automatic t_pattern;
        ctl.send(DBMR_CMD_MRS, DBMR_MODE_SEL0, 16'h102a);
        ctl.send(DBMR_CMD_MRS, DBMR_MODE_SEL3, 16'h0004);
        for (int h = 1; h >= 0; h--)
        begin
            do_read(16'(h << 2));
            for (int b = 0; b < 4; b++)
                check("pattern nibble", {16{PAT[4 * h + b]}}, beats[b]);
        end
        ctl.send(DBMR_CMD_MRS, DBMR_MODE_SEL0, 16'h1028);
        do_read(16'h0004);
        for (int b = 0; b < 8; b++)
            check("pattern wrap", {16{PAT[(4 + b) % 8]}}, beats[b]);
        ctl.send(DBMR_CMD_MRS, DBMR_MODE_SEL3, 16'h0000);
        $display("test pattern done");
    endtask : t_pattern

    task automatic t_async;
        ctl.set_cke(1'b0);
        repeat (4) @(negedge sys_clk);
        check("odt_async loop live", 16'h0000, {15'h0000, odt_async});
        ctl.set_cke(1'b1);
        ctl.mode_calib(DBMR_MODE_SEL0, 16'h0028);
        ctl.set_cke(1'b0);
        repeat (3) @(negedge sys_clk);
        check("odt_async entry", 16'h0001, {15'h0000, odt_async});
        repeat (5) @(negedge sys_clk);
        check("odt_async held", 16'h0001, {15'h0000, odt_async});
        ctl.set_cke(1'b1);
        repeat (3) @(negedge sys_clk);
        check("odt_async exit", 16'h0001, {15'h0000, odt_async});
        repeat (2) @(negedge sys_clk);
        check("odt_async window end", 16'h0000, {15'h0000, odt_async});
        // write cas latency six stretches the window to five clocks
        ctl.send(DBMR_CMD_MRS, DBMR_MODE_SEL2, 16'h0030);
        ctl.set_cke(1'b0);
        repeat (4) @(negedge sys_clk);
        ctl.set_cke(1'b1);
        repeat (5) @(negedge sys_clk);
        check("odt_async wide window", 16'h0001, {15'h0000, odt_async});
        @(negedge sys_clk);
        check("odt_async wide end", 16'h0000, {15'h0000, odt_async});
        ctl.send(DBMR_CMD_MRS, DBMR_MODE_SEL2, 16'h0028);
        ctl.mode_calib(DBMR_MODE_SEL0, 16'h1028);
        $display("test async done");
    endtask : t_async

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        $display("watchdog expired");
        summarize();
    end

    initial
    begin
        repeat (10) @(negedge sys_clk);
        check("rd_valid in reset", 16'h0000, {15'h0000, rd_valid});
        rst_n = 1'b1;
        t_burst();
        t_latency();
        t_pattern();
        t_async();
        summarize();
    end
endmodule : tb
